/* File: src/cpwm_regs.vh */
`ifndef CPWM_REGS_VH
`define CPWM_REGS_VH
// register offsets, byte addresses on an 8-bit data port
`define CPWM_OFS_CTRL      4'h0
`define CPWM_OFS_DUTY      4'h1
`define CPWM_OFS_SHADOW    4'h2
`define CPWM_OFS_PERIOD    4'h3
`define CPWM_OFS_TCTRL     4'h4
`define CPWM_OFS_TSEL      4'h5
`define CPWM_OFS_PIN       4'h6
`define CPWM_OFS_STATUS    4'h7
`define CPWM_OFS_MASK      4'h8
`define CPWM_OFS_COUNT     4'h9
// module control fields
`define CPWM_MODE_LSB      0
`define CPWM_MODE_MSB      3
`define CPWM_DLOW_LSB      4
`define CPWM_DLOW_MSB      5
`define CPWM_ECFG_LSB      6
`define CPWM_ECFG_MSB      7
`define CPWM_MODE_PWM      2'h3
// timer control fields
`define CPWM_TON_BIT       2
`define CPWM_PRE_LSB       0
`define CPWM_PRE_MSB       1
// last prescaler phase before a timer count: 1:4, 1:16, 1:64, 1:256
`define CPWM_PRE_LAST0     8'h03
`define CPWM_PRE_LAST1     8'h0F
`define CPWM_PRE_LAST2     8'h3F
`define CPWM_PRE_LAST3     8'hFF
// status bits
`define CPWM_ST_MATCH      0
`define CPWM_ST_PERIOD     1
// reset values and timer count
`define CPWM_RST_BYTE      8'h00
`define CPWM_RST_PIN_DIR   1'b1
`define CPWM_NUM_TIMERS    3
`endif

/* File: src/cpwm_prescaler.v */
`timescale 1ns/1ps
`include "cpwm_regs.vh"
module cpwm_prescaler (
   input  wire       clk,
   input  wire       rst,
   input  wire       run,
   input  wire [1:0] prescale,
   output reg  [1:0] fine,
   output wire       tick
);
   reg  [7:0] div;
   reg  [7:0] last;
   // one timer count spans 4, 16, 64 or 256 clocks; the top two phase bits extend the time base
   always @* begin
      case (prescale)
         2'h0: begin
            last = `CPWM_PRE_LAST0;
            fine = div[1:0];
         end
         2'h1: begin
            last = `CPWM_PRE_LAST1;
            fine = div[3:2];
         end
         2'h2: begin
            last = `CPWM_PRE_LAST2;
            fine = div[5:4];
         end
         default: begin
            last = `CPWM_PRE_LAST3;
            fine = div[7:6];
         end
      endcase
   end
   // a prescale change mid-count wraps at once instead of running on to 255
   assign tick = run && (div >= last);
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         div <= 8'h00;
      end else if (run) begin
         if (div >= last)
            div <= 8'h00;
         else
            div <= div + 8'h01;
      end
   end
endmodule

/* File: src/cpwm_timer.v */
`timescale 1ns/1ps
`include "cpwm_regs.vh"
module cpwm_timer (
   input  wire       clk,
   input  wire       rst,
   input  wire       tick,
   input  wire [7:0] period_reg,
   output reg  [7:0] count,
   output wire       rollover
);
   // rollover is the increment that follows count == period
   assign rollover = tick && (count == period_reg);
   always @(posedge clk or posedge rst) begin
      if (rst)
         count <= 8'h00;
      else if (rollover)
         count <= 8'h00;
      else if (tick)
         count <= count + 8'h01;
   end
endmodule

/* File: src/cpwm_unit.v */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "cpwm_regs.vh"
// What this block does
// (R01) Compare timing rests on the system clock, so nothing advances while that clock is stopped.
// (R02) In PWM mode the block drives a pulse train on its output pin with up to ten bits resolution.
// (R03) The pin is driven only while software holds the pin direction bit cleared.
// (R04) An all-zero module control register releases the output pin.
// (R05) Period, duty and resolution come from period, timer control, duty and control registers.
// (R06) Software sets the pin input, loads period, selects PWM, then loads the duty value.
// (R07) Software then picks the timer, clears its flag, sets prescale and starts the timer.
// (R08) Software may wait for the timer flag before enabling the pin for a clean first pulse.
// (R09) A zero duty keeps the pin low and a duty beyond the period keeps it high.
// (R10) The enhanced output field is not implemented in this standard unit.
// (R11) Unimplemented bits always read as zero.
// (R12) On the increment after timer equals period the timer clears, pin sets unless duty is zero,
//       and the duty byte is copied into the shadow byte.
// (R13) The ten-bit duty is the duty byte on top with the two low duty bits below.
// (R14) The pin clears when the ten-bit time base equals the shadow byte with its two-bit latch.
module cpwm_unit (
   input  wire       clk,
   input  wire       rst,
   input  wire [3:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   output wire       pin_out,
   output wire       pin_oe,
   output wire       irq
);
   reg  [5:0] module_control_reg;
   reg  [7:0] duty_byte_reg;
   reg  [7:0] duty_shadow_byte;
   reg  [1:0] shadow_low;
   reg  [7:0] period_reg;
   reg  [2:0] period_timer_control;
   reg  [1:0] timer_select_field;
   reg        pin_direction_bit;
   reg  [1:0] status;
   reg  [1:0] mask;
   reg        pwm_level;
   reg        period_start;
   reg  [7:0] next_rdata;
   wire [3:0] module_mode_field;
   wire [1:0] duty_low_bits;
   wire       pwm_mode;
   wire       module_off;
   wire       timer_on_bit;
   wire [1:0] timer_prescale_field;
   wire [1:0] fine;
   wire       tick;
   wire [7:0] period_timer_count;
   wire       rollover;
   wire [9:0] time_base;
   wire [9:0] next_duty;
   wire       duty_match;
   wire [1:0] events;

   assign module_mode_field    = module_control_reg[`CPWM_MODE_MSB:`CPWM_MODE_LSB];
   assign duty_low_bits        = module_control_reg[`CPWM_DLOW_MSB:`CPWM_DLOW_LSB];
   assign pwm_mode             = (module_mode_field[3:2] == `CPWM_MODE_PWM); // R05
   assign module_off           = (module_control_reg == 6'h00); // R04
   assign timer_on_bit         = period_timer_control[`CPWM_TON_BIT];
   assign timer_prescale_field = period_timer_control[`CPWM_PRE_MSB:`CPWM_PRE_LSB];
   // only one timer instance stands behind the select field; the other codes stop it
   wire timer_run = timer_on_bit && (timer_select_field == 2'h0);

   // counts advance only on clk, so a stopped clock freezes the waveform
   cpwm_prescaler u_pre ( // R01
      .clk      (clk),
      .rst      (rst),
      .run      (timer_run),
      .prescale (timer_prescale_field),
      .fine     (fine),
      .tick     (tick)
   );

   cpwm_timer u_tmr (
      .clk        (clk),
      .rst        (rst),
      .tick       (tick),
      .period_reg (period_reg),
      .count      (period_timer_count),
      .rollover   (rollover)
   );

   assign time_base  = {period_timer_count, fine}; // R02
   assign next_duty  = {duty_byte_reg, duty_low_bits}; // R13
   assign duty_match = timer_run && (time_base == {duty_shadow_byte, shadow_low}); // R14

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         duty_shadow_byte <= `CPWM_RST_BYTE;
         shadow_low       <= 2'h0;
         period_start     <= 1'b0;
         pwm_level        <= 1'b0;
      end else begin
         period_start <= rollover;
         if (rollover && pwm_mode) begin
            {duty_shadow_byte, shadow_low} <= next_duty; // R12 R13
         end
         // set and clear both lag the time base by one clock, so the width stays exact
         if (!pwm_mode)
            pwm_level <= 1'b0; // R04
         else if (duty_match)
            pwm_level <= 1'b0; // R14
         else if (period_start)
            pwm_level <= ({duty_shadow_byte, shadow_low} != 10'h000); // R09 R12
      end
   end

   // duty beyond the period never matches, so the pin stays high (R09)
   assign pin_out = pwm_level;
   assign pin_oe  = pwm_mode && !module_off && !pin_direction_bit; // R03

   assign events = {rollover, duty_match};

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         module_control_reg   <= 6'h00;
         duty_byte_reg        <= `CPWM_RST_BYTE;
         period_reg           <= `CPWM_RST_BYTE;
         period_timer_control <= 3'h0;
         timer_select_field   <= 2'h0;
         pin_direction_bit    <= `CPWM_RST_PIN_DIR;
         mask                 <= 2'h0;
      end else if (wr) begin
         case (addr)
            `CPWM_OFS_CTRL:   module_control_reg   <= wdata[5:0]; // R10
            `CPWM_OFS_DUTY:   duty_byte_reg        <= wdata;
            `CPWM_OFS_PERIOD: period_reg           <= wdata;
            `CPWM_OFS_TCTRL:  period_timer_control <= wdata[2:0];
            `CPWM_OFS_TSEL:   timer_select_field   <= wdata[1:0];
            `CPWM_OFS_PIN:    pin_direction_bit    <= wdata[0];
            `CPWM_OFS_MASK:   mask                 <= wdata[1:0];
            default: ;
         endcase
      end
   end

   // sticky status, a new event wins over a write-one clear
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_st
         always @(posedge clk or posedge rst) begin
            if (rst)
               status[i] <= 1'b0;
            else if (events[i])
               status[i] <= 1'b1;
            else if (wr && addr == `CPWM_OFS_STATUS && wdata[i])
               status[i] <= 1'b0;
         end
      end
   endgenerate

   assign irq = |(status & mask);

   always @* begin
      next_rdata = 8'h00;
      case (addr)
         `CPWM_OFS_CTRL:   next_rdata = {2'h0, module_control_reg}; // R11
         `CPWM_OFS_DUTY:   next_rdata = duty_byte_reg;
         `CPWM_OFS_SHADOW: next_rdata = duty_shadow_byte;
         `CPWM_OFS_PERIOD: next_rdata = period_reg;
         `CPWM_OFS_TCTRL:  next_rdata = {5'h00, period_timer_control};
         `CPWM_OFS_TSEL:   next_rdata = {6'h00, timer_select_field};
         `CPWM_OFS_PIN:    next_rdata = {7'h00, pin_direction_bit};
         `CPWM_OFS_STATUS: next_rdata = {6'h00, status};
         `CPWM_OFS_MASK:   next_rdata = {6'h00, mask};
         `CPWM_OFS_COUNT:  next_rdata = period_timer_count;
         default:          next_rdata = 8'h00;
      endcase
   end

   always @(posedge clk or posedge rst) begin
      if (rst)
         rdata <= 8'h00;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end
endmodule

/* File: bench/cpwm_load.sv */
`timescale 1ns/1ps
module cpwm_load (
   input  wire  clk,
   input  wire  drv,
   input  wire  oe,
   output logic level
);
   logic last = 1'b0;
   // released pin shows a changing level, so a stale value cannot pass
   always @(posedge clk) begin
      last <= oe ? drv : ~last;
   end
   assign level = oe ? drv : last;
endmodule

/* File: bench/cpwm_unit_assertions.sv */
`timescale 1ns/1ps
module cpwm_unit_assertions (
   input wire       clk,
   input wire       rst,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire       wr,
   input wire       rd,
   input wire [7:0] rdata,
   input wire       pin_out,
   input wire       pin_oe,
   input wire       irq
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its slot");
   a_unmapped_zero: assert property (rd && addr > 4'h9 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_no_ecfg: assert property (rd && addr == 4'h0 |=> rdata[7:6] == 2'h0)
      else $error("enhanced field reads nonzero");
   a_dir_upper: assert property (rd && addr == 4'h6 |=> rdata[7:1] == 7'h00)
      else $error("direction upper bits nonzero");
   a_status_upper: assert property (rd && addr == 4'h7 |=> rdata[7:2] == 6'h00)
      else $error("status upper bits nonzero");
   a_dir_release: assert property (wr && addr == 4'h6 && wdata[0] |=> !pin_oe)
      else $error("pin driven while direction set");
   a_ctrl_release: assert property (wr && addr == 4'h0 && wdata == 8'h00 |=> !pin_oe)
      else $error("pin kept after control cleared");
   a_oe_by_write: assert property ($changed(pin_oe) |-> $past(wr))
      else $error("output enable moved without a write");
   a_off_pin_low: assert property (wr && addr == 4'h0 && wdata[3:2] != 2'h3 |=> ##1 !pin_out)
      else $error("pin level kept outside PWM mode");
endmodule

bind cpwm_unit cpwm_unit_assertions i_cpwm_unit_assertions (.clk(clk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe),
   .irq(irq));

/* File: bench/cpwm_unit_tb_top.sv */
`timescale 1ns/1ps
module cpwm_unit_tb_top;
   logic       clk = 1'b0;
   logic       rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   wire  [7:0] rdata;
   wire        pin_out;
   wire        pin_oe;
   wire        irq;
   wire        level;
   int         errors = 0;
   int         check_count = 0;
   logic [7:0] v;
   cpwm_unit i_cpwm_unit (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
   cpwm_load i_cpwm_load (.clk(clk), .drv(pin_out), .oe(pin_oe), .level(level));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input [7:0] got, input [7:0] exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input [3:0] a, input [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input [3:0] a, output [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic t_regs;
      for (int a = 0; a < 16; a++) begin
         rreg(a[3:0], v);
         chk(v, (a == 6) ? 8'h01 : 8'h00);
      end
      wreg(4'h0, 8'hFF);
      rreg(4'h0, v);
      chk(v, 8'h3F);
      wreg(4'hC, 8'hFF);
      rreg(4'hC, v);
      chk(v, 8'h00);
      $display("register test done");
   endtask
   task automatic t_pwm;
      int n;
      logic [9:0] d;
      logic [9:0] dt [5] = '{10'h000, 10'h005, 10'h007, 10'h00A, 10'h014};
      wreg(4'h6, 8'h01);
      wreg(4'h3, 8'h03);
      wreg(4'h0, 8'h0C);
      wreg(4'h1, 8'h00);
      wreg(4'h5, 8'h00);
      wreg(4'h7, 8'h03);
      wreg(4'h4, 8'h04);
      v = 8'h00;
      // bounded wait for the first rollover
      repeat (50) if (!v[1]) rreg(4'h7, v);
      chk(v & 8'h02, 8'h02);
      if (!v[1]) report_and_stop();
      wreg(4'h6, 8'h00);
      #1 chk({7'h00, pin_oe}, 8'h01);
      for (int i = 0; i < 5; i++) begin
         d = dt[i];
         wreg(4'h0, {2'h0, d[1:0], 4'hC});
         wreg(4'h1, d[9:2]);
         repeat (40) @(posedge clk);
         rreg(4'h2, v);
         chk(v, d[9:2]);
         n = 0;
         repeat (64) begin
            @(negedge clk);
            n += level;
         end
         chk(n[7:0], (d > 10'h00F) ? 8'h40 : {d[5:0], 2'h0});
      end
      wreg(4'h0, 8'h00);
      #1 chk({7'h00, pin_oe}, 8'h00);
      $display("pwm test done");
   endtask
   task automatic t_irq;
      wreg(4'h8, 8'h02);
      repeat (20) @(posedge clk);
      #1 chk({7'h00, irq}, 8'h01);
      wreg(4'h8, 8'h00);
      #1 chk({7'h00, irq}, 8'h00);
      wreg(4'h8, 8'h02);
      #1 chk({7'h00, irq}, 8'h01);
      wreg(4'h4, 8'h00);
      wreg(4'h7, 8'h03);
      #1 chk({7'h00, irq}, 8'h00);
      $display("interrupt test done");
   endtask
   task automatic t_pre;
      int n;
      logic [7:0] c;
      wreg(4'h0, 8'h1C);
      wreg(4'h1, 8'h01);
      for (int p = 1; p < 4; p++) begin
         wreg(4'h4, {6'h01, p[1:0]});
         repeat (2100) @(posedge clk);
         n = 0;
         repeat (1024) begin
            @(negedge clk);
            n += level;
         end
         chk(n[9:2], 8'h50);
      end
      wreg(4'h4, 8'h04);
      wreg(4'h5, 8'h01);
      rreg(4'h9, c);
      repeat (20) @(posedge clk);
      rreg(4'h9, v);
      chk(v, c);
      wreg(4'h5, 8'h00);
      $display("prescale test done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_pwm();
      t_irq();
      t_pre();
      report_and_stop();
   end
endmodule
